// [sram_access_pkg.sv]
// Package: register map, field layout and carrier types of the buffer access bank
package sram_access_pkg;

  // ************************************************************
  // Register word indices (printed offsets are not all word aligned,
  // so each is an index and the byte address is four times it)
  // ************************************************************
  localparam logic [7:0] idx_rd_addr_high = 8'hf5;
  localparam logic [7:0] idx_rd_addr_low  = 8'hf4;
  localparam logic [7:0] idx_tx_hold      = 8'hf6;
  localparam logic [7:0] idx_tx_advance   = 8'hf8;
  localparam logic [7:0] idx_rx_peek      = 8'hf0;
  localparam logic [7:0] idx_rx_advance   = 8'hf2;
  localparam logic [7:0] idx_wr_addr_low  = 8'hfa;
  localparam logic [7:0] idx_wr_addr_high = 8'hfb;
  localparam logic [7:0] idx_len_low      = 8'hfc;
  localparam logic [7:0] idx_len_high     = 8'hfd;
  localparam logic [7:0] idx_status       = 8'hfe;
  localparam logic [7:0] idx_enable       = 8'hff;

  // ************************************************************
  // Field positions and constants
  // ************************************************************
  localparam int          bus_width_bit   = 7;
  localparam int          wrap_enable_bit = 7;
  localparam logic [7:0]  event_mask      = 8'h3f;
  localparam logic [7:0]  wrap_high_value = 8'h0c;
  localparam logic [15:0] step_byte       = 16'h0001;
  localparam logic [15:0] step_word       = 16'h0002;
  localparam logic [15:0] addr_reset      = 16'h0000;
  localparam logic [7:0]  byte_reset      = 8'h00;
  localparam logic [1:0]  resp_okay       = 2'b00;
  localparam logic [1:0]  resp_slverr     = 2'b10;

  // Event inputs, one pulse each, same bit order as the status register
  typedef struct packed {
    logic link_change;
    logic tx_underflow;
    logic rx_overflow_count_wrap;
    logic rx_overflow;
    logic frame_sent;
    logic frame_received;
  } events_t;

  // Buffer memory write request towards the transmit buffer
  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] data;
    logic        word;
  } mem_wr_t;

  // Bus slave handshake states, Gray coded
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_resp = 2'b01
  } bus_state_t;

endpackage : sram_access_pkg

// [addr_step.sv]
// Buffer pointer advance with optional wrap back to the buffer start
`timescale 1ns/10ps
`default_nettype none
module addr_step #(
  parameter logic [15:0] wrap_start = 16'h0c00,
  parameter logic [15:0] wrap_end   = 16'h3fff
) (
  // Current pointer and mode
  input  wire logic [15:0] addr_i,
  input  wire logic        word_mode_i,
  input  wire logic        wrap_en_i,
  // Advanced pointer
  output logic      [15:0] next_addr_o
);

  logic [15:0] sum;

  // Step by one byte or one word; wrap only when enabled
  always_comb begin
    sum = addr_i + (word_mode_i ? sram_access_pkg::step_word
                                : sram_access_pkg::step_byte);
    if (wrap_en_i && (sum > wrap_end)) begin
      next_addr_o = wrap_start + (sum - wrap_end - 16'h0001);
    end else begin
      next_addr_o = sum;
    end
  end

endmodule // addr_step
`default_nettype wire

// [sram_access_irq_regs.sv]
// Buffer access ports, pointers, frame length and event registers
// Notes on behaviour
// - Write to hold port stores data at write pointer, pointer stays.
// - Write to advance port stores data, pointer rises 1 or 2.
// - Read pointer is 16 bits, high and low bytes, read and write.
// - Setting wrap enable loads read pointer high byte with 0Ch.
// - Write pointer is 16 bits, high and low bytes, host loadable.
// - Frame length is 16 bits, high and low bytes, read and write.
// - Status bit 7 is read-only bus width: 1 byte-wide, 0 word-wide.
// - Six event flags set by hardware, cleared by writing one.
// - Enable bits 5..0 gate matching flags onto the interrupt.
// - With wrap enable set, pointers wrap past buffer end to start.
// - Read of advancing receive port returns data, pointer rises 1 or 2.
// - Read of peek port keeps pointer and starts a prefetch.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module sram_access_irq_regs #(
  parameter logic [15:0] wrap_start = 16'h0c00,
  parameter logic [15:0] wrap_end   = 16'h3fff
) (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rstn_i,
  // AXI4-Lite write address and data
  input  wire logic                     s_axi_awvalid_i,
  output logic                          s_axi_awready_o,
  input  wire logic [9:0]               s_axi_awaddr_i,
  input  wire logic                     s_axi_wvalid_i,
  output logic                          s_axi_wready_o,
  input  wire logic [31:0]              s_axi_wdata_i,
  input  wire logic [3:0]               s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                          s_axi_bvalid_o,
  input  wire logic                     s_axi_bready_i,
  output logic [1:0]                    s_axi_bresp_o,
  // AXI4-Lite read
  input  wire logic                     s_axi_arvalid_i,
  output logic                          s_axi_arready_o,
  input  wire logic [9:0]               s_axi_araddr_i,
  output logic                          s_axi_rvalid_o,
  input  wire logic                     s_axi_rready_i,
  output logic [31:0]                   s_axi_rdata_o,
  output logic [1:0]                    s_axi_rresp_o,
  // Bus width strap pin, 1 for byte-wide mode
  input  wire logic                     bus_width_strap_i,
  // Event pulses from the frame engines
  input  wire sram_access_pkg::events_t events_i,
  // Receive buffer read data, valid the cycle after its address
  input  wire logic [15:0]              rx_mem_data_i,
  // Buffer memory side
  output sram_access_pkg::mem_wr_t      tx_mem_o,
  output logic [15:0]                   rx_mem_addr_o,
  output logic                          rx_prefetch_o,
  output logic [15:0]                   tx_frame_length_o,
  // Interrupt request
  output logic                          irq_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    sram_access_pkg::bus_state_t wst;
    sram_access_pkg::bus_state_t rst;
    logic                        awready;
    logic                        wready;
    logic                        aw_held;
    logic                        w_held;
    logic [7:0]                  aw_idx;
    logic [31:0]                 wdata;
    logic                        arready;
    logic [1:0]                  bresp;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic                        strap_meta;
    logic                        strap_sync;
    logic [7:0]                  status;
    logic [7:0]                  enable;
    logic [15:0]                 rd_addr;
    logic [15:0]                 wr_addr;
    logic [15:0]                 length;
    sram_access_pkg::mem_wr_t    tx_mem;
    logic                        prefetch;
    logic                        irq;
  } state_t;

  state_t st;
  state_t next_st;

  logic [15:0] wr_addr_adv;
  logic [15:0] rd_addr_adv;
  logic        word_mode;
  logic        wrap_en;

  // Word index from a byte address; low two bits ignored
  function automatic logic [7:0] reg_index(input logic [9:0] a);
    reg_index = a[9:2];
  endfunction

  // Any mapped index answers OKAY, the rest SLVERR
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == sram_access_pkg::idx_rd_addr_high) ||
             (i == sram_access_pkg::idx_rd_addr_low)  ||
             (i == sram_access_pkg::idx_tx_hold)      ||
             (i == sram_access_pkg::idx_tx_advance)   ||
             (i == sram_access_pkg::idx_rx_peek)      ||
             (i == sram_access_pkg::idx_rx_advance)   ||
             (i == sram_access_pkg::idx_wr_addr_low)  ||
             (i == sram_access_pkg::idx_wr_addr_high) ||
             (i == sram_access_pkg::idx_len_low)      ||
             (i == sram_access_pkg::idx_len_high)     ||
             (i == sram_access_pkg::idx_status)       ||
             (i == sram_access_pkg::idx_enable);
  endfunction

  assign word_mode = ~st.strap_sync;
  assign wrap_en   = st.enable[sram_access_pkg::wrap_enable_bit];

  // ************************************************************
  // Pointer advance, one instance for each buffer direction
  // ************************************************************
  addr_step #(
    .wrap_start (wrap_start),
    .wrap_end   (wrap_end)
  ) u_wr_step (
    .addr_i      (st.wr_addr),
    .word_mode_i (word_mode),
    .wrap_en_i   (wrap_en),
    .next_addr_o (wr_addr_adv)
  );

  addr_step #(
    .wrap_start (wrap_start),
    .wrap_end   (wrap_end)
  ) u_rd_step (
    .addr_i      (st.rd_addr),
    .word_mode_i (word_mode),
    .wrap_en_i   (wrap_en),
    .next_addr_o (rd_addr_adv)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic        do_wr;
    logic [7:0]  widx;
    logic [7:0]  ridx;
    logic [7:0]  wb;
    logic [7:0]  rb;
    logic        do_rd;
    do_wr = 1'b0;
    widx = 8'h00;
    ridx = 8'h00;
    wb = 8'h00;
    rb = 8'h00;
    do_rd = 1'b0;
    next_st = st;
    next_st.tx_mem.write = 1'b0;
    next_st.prefetch = 1'b0;
    // Strap crosses in on two flops before use
    next_st.strap_meta = bus_width_strap_i;
    next_st.strap_sync = st.strap_meta;

    // Capture address and data in either order
    if (s_axi_awvalid_i && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awready = 1'b0;
      next_st.aw_idx  = reg_index(s_axi_awaddr_i);
    end
    if (s_axi_wvalid_i && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wready = 1'b0;
      next_st.wdata  = s_axi_wdata_i;
    end

    // Write executes once both halves are held
    if (st.wst == sram_access_pkg::st_idle && st.aw_held && st.w_held) begin
      do_wr = 1'b1;
      widx  = st.aw_idx;
      wb    = st.wdata[7:0];
      next_st.wst     = sram_access_pkg::st_resp;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bresp   = mapped(widx) ? sram_access_pkg::resp_okay
                                     : sram_access_pkg::resp_slverr;
    end
    if (st.wst == sram_access_pkg::st_resp && s_axi_bready_i) begin
      next_st.wst     = sram_access_pkg::st_idle;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // Event flags: hardware set wins over a same-cycle clear
    if (do_wr && widx == sram_access_pkg::idx_status) begin
      next_st.status = st.status & ~(wb & sram_access_pkg::event_mask);
    end
    next_st.status = (next_st.status & sram_access_pkg::event_mask)
                   | ({2'b00, events_i} & sram_access_pkg::event_mask);

    if (do_wr) begin
      case (widx)
        sram_access_pkg::idx_rd_addr_low:  next_st.rd_addr[7:0]  = wb;
        sram_access_pkg::idx_rd_addr_high: next_st.rd_addr[15:8] = wb;
        sram_access_pkg::idx_wr_addr_low:  next_st.wr_addr[7:0]  = wb;
        sram_access_pkg::idx_wr_addr_high: next_st.wr_addr[15:8] = wb;
        sram_access_pkg::idx_len_low:      next_st.length[7:0]   = wb;
        sram_access_pkg::idx_len_high:     next_st.length[15:8]  = wb;
        sram_access_pkg::idx_enable: begin
          // Bit 6 is reserved and stays zero
          next_st.enable = wb & (sram_access_pkg::event_mask |
                           (8'h01 << sram_access_pkg::wrap_enable_bit));
          if (wb[sram_access_pkg::wrap_enable_bit]) begin
            next_st.rd_addr[15:8] = sram_access_pkg::wrap_high_value;
          end
        end
        sram_access_pkg::idx_tx_hold: begin
          next_st.tx_mem = '{1'b1, st.wr_addr, st.wdata[15:0], word_mode};
        end
        sram_access_pkg::idx_tx_advance: begin
          next_st.tx_mem  = '{1'b1, st.wr_addr, st.wdata[15:0], word_mode};
          next_st.wr_addr = wr_addr_adv;
        end
        default: begin
        end
      endcase
    end

    // Read channel: answer one cycle after the address is taken
    if (st.rst == sram_access_pkg::st_idle && s_axi_arvalid_i) begin
      do_rd = 1'b1;
      ridx  = reg_index(s_axi_araddr_i);
      next_st.arready = 1'b0;
      next_st.rst     = sram_access_pkg::st_resp;
      next_st.rresp   = mapped(ridx) ? sram_access_pkg::resp_okay
                                     : sram_access_pkg::resp_slverr;
    end
    if (st.rst == sram_access_pkg::st_resp && s_axi_rready_i) begin
      next_st.rst     = sram_access_pkg::st_idle;
      next_st.arready = 1'b1;
    end

    if (do_rd) begin
      case (ridx)
        sram_access_pkg::idx_rd_addr_low:  rb = st.rd_addr[7:0];
        sram_access_pkg::idx_rd_addr_high: rb = st.rd_addr[15:8];
        sram_access_pkg::idx_wr_addr_low:  rb = st.wr_addr[7:0];
        sram_access_pkg::idx_wr_addr_high: rb = st.wr_addr[15:8];
        sram_access_pkg::idx_len_low:      rb = st.length[7:0];
        sram_access_pkg::idx_len_high:     rb = st.length[15:8];
        sram_access_pkg::idx_enable:       rb = st.enable;
        sram_access_pkg::idx_status: begin
          rb = st.status;
          rb[sram_access_pkg::bus_width_bit] = st.strap_sync;
        end
        sram_access_pkg::idx_rx_peek: begin
          next_st.prefetch = 1'b1;
        end
        sram_access_pkg::idx_rx_advance: begin
          next_st.rd_addr = rd_addr_adv;
        end
        default: rb = 8'h00;
      endcase
      next_st.rdata = {24'h00_0000, rb};
      // Data ports return memory data; upper half only in word mode
      if (ridx == sram_access_pkg::idx_rx_peek ||
          ridx == sram_access_pkg::idx_rx_advance) begin
        next_st.rdata = {16'h0000, word_mode ? rx_mem_data_i[15:8] : 8'h00,
                         rx_mem_data_i[7:0]};
      end
    end

    next_st.irq = |(next_st.status & st.enable & sram_access_pkg::event_mask);
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '{wst: sram_access_pkg::st_idle, rst: sram_access_pkg::st_idle,
              awready: 1'b1, wready: 1'b1, arready: 1'b1,
              rd_addr: sram_access_pkg::addr_reset,
              wr_addr: sram_access_pkg::addr_reset,
              status: sram_access_pkg::byte_reset,
              enable: sram_access_pkg::byte_reset,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops; rdata is one cycle behind the address
  assign s_axi_awready_o   = st.awready;
  assign s_axi_wready_o    = st.wready;
  assign s_axi_bvalid_o    = (st.wst == sram_access_pkg::st_resp);
  assign s_axi_bresp_o     = st.bresp;
  assign s_axi_arready_o   = st.arready;
  assign s_axi_rvalid_o    = (st.rst == sram_access_pkg::st_resp);
  assign s_axi_rdata_o     = st.rdata;
  assign s_axi_rresp_o     = st.rresp;
  assign tx_mem_o          = st.tx_mem;
  assign rx_mem_addr_o     = st.rd_addr;
  assign rx_prefetch_o     = st.prefetch;
  assign tx_frame_length_o = st.length;
  assign irq_o             = st.irq;

endmodule // sram_access_irq_regs
`default_nettype wire

// [sram_access_irq_regs_asserts.sv]
// Checker: port-level timing relations of the buffer access register bank
`timescale 1ns/10ps
`default_nettype none
module sram_access_irq_regs_asserts (
  // Clock and reset
  input wire logic                     ref_clk_i,
  input wire logic                     rstn_i,
  // Register bus
  input wire logic                     s_axi_awvalid_i,
  input wire logic                     s_axi_awready_o,
  input wire logic                     s_axi_wvalid_i,
  input wire logic                     s_axi_wready_o,
  input wire logic                     s_axi_bvalid_o,
  input wire logic                     s_axi_arvalid_i,
  input wire logic                     s_axi_arready_o,
  input wire logic                     s_axi_rvalid_o,
  // Device side
  input wire logic                     bus_width_strap_i,
  input wire sram_access_pkg::events_t events_i,
  input wire sram_access_pkg::mem_wr_t tx_mem_o,
  input wire logic [15:0]              rx_mem_addr_o,
  input wire logic                     rx_prefetch_o,
  input wire logic                     irq_o
);
  // *************************************************
  // Clocking and handshake steps
  // *************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Address and data taken at one edge, as the bench offers them
  sequence aw_w_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence ar_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  // *************************************************
  // Assertions
  // *************************************************
  AST_B_ANSWER: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response missing");
  AST_R_ANSWER: assert property (ar_taken |-> ##[1:2] s_axi_rvalid_o)
    else $error("read data missing");
  AST_WR_WITH_RESP: assert property (
    tx_mem_o.write |-> $rose(s_axi_bvalid_o))
    else $error("buffer write not tied to a host write");
  AST_WR_PULSE: assert property (
    tx_mem_o.write |=> !tx_mem_o.write)
    else $error("buffer write longer than one cycle");
  AST_WR_WIDTH: assert property (
    tx_mem_o.write |-> tx_mem_o.word == !$past(bus_width_strap_i, 3))
    else $error("buffer write width disagrees with strap");
  AST_PEEK_PULSE: assert property (
    rx_prefetch_o |=> !rx_prefetch_o)
    else $error("prefetch pulse too long");
  AST_PEEK_KEEPS: assert property (
    rx_prefetch_o |-> rx_mem_addr_o == $past(rx_mem_addr_o, 2))
    else $error("peek read moved the read pointer");
  // Pointer moves only around a host access completing
  AST_PTR_CAUSE: assert property (
    $changed(rx_mem_addr_o) |-> s_axi_rvalid_o || s_axi_bvalid_o
      || $past(s_axi_rvalid_o) || $past(s_axi_bvalid_o))
    else $error("read pointer moved without host access");
  AST_IRQ_RISE: assert property (
    $rose(irq_o) |-> $past(events_i != '0, 2) || $past(events_i != '0)
      || $past(s_axi_bvalid_o))
    else $error("interrupt rose without event or enable write");
  // A clear lands with the response edge, so bvalid stands as irq drops
  AST_IRQ_FALL: assert property (
    $fell(irq_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
    else $error("interrupt fell without host write");
endmodule // sram_access_irq_regs_asserts

bind sram_access_irq_regs sram_access_irq_regs_asserts u_asserts (
  .ref_clk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .bus_width_strap_i, .events_i, .tx_mem_o,
  .rx_mem_addr_o, .rx_prefetch_o, .irq_o
);
`default_nettype wire

// [rx_buffer_model.sv]
// Receive buffer memory model: registered read, data a pattern of address
`timescale 1ns/10ps
`default_nettype none
module rx_buffer_model #(
  parameter logic [15:0] pattern = 16'h5a3c
) (
  // Clock and read address
  input wire logic        clk_i,
  input wire logic [15:0] addr_i,
  // Read data, one cycle after the address
  output logic     [15:0] data_o
);
  // Synchronous read, like the real buffer array
  always_ff @(posedge clk_i) begin
    data_o <= addr_i ^ pattern;
  end
endmodule // rx_buffer_model
`default_nettype wire

// [sram_access_irq_regs_tb_top.sv]
// Testbench: register bank traffic, pointer, wrap and event checks
`timescale 1ns/10ps
`default_nettype none
module sram_access_irq_regs_tb_top;
  // *************************************************
  // Signals
  // *************************************************
  logic                     clk = 1'b0, rstn = 1'b0, strap = 1'b0;
  logic                     awv = 1'b0, wv = 1'b0, brd = 1'b0;
  logic                     arv = 1'b0, rrd = 1'b0;
  logic [9:0]               awa = 10'h000, ara = 10'h000;
  logic [31:0]              wd = 32'h0000_0000, rdat;
  sram_access_pkg::events_t ev = '0;
  logic                     awr, wrr, bv, arr, rv, pf, irq;
  logic [1:0]               bresp, rresp, er;
  logic [15:0]              rxa, rxd, tlen;
  sram_access_pkg::mem_wr_t tx, last_wr;
  int                       failures = 0, n_compared = 0, n_pf = 0;

  sram_access_irq_regs dut (
    .ref_clk_i(clk), .rstn_i(rstn),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(brd),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
    .bus_width_strap_i(strap), .events_i(ev), .rx_mem_data_i(rxd),
    .tx_mem_o(tx), .rx_mem_addr_o(rxa), .rx_prefetch_o(pf),
    .tx_frame_length_o(tlen), .irq_o(irq)
  );
  rx_buffer_model u_mem (.clk_i(clk), .addr_i(rxa), .data_o(rxd));

  // Clock, 8 ns period
  initial forever #4 clk = ~clk;

  // Capture buffer writes and prefetch pulses as they stand
  always @(posedge clk) begin
    if (tx.write === 1'b1) last_wr <= tx;
    if (pf === 1'b1) n_pf <= n_pf + 1;
  end

  // *************************************************
  // Tasks and expectation functions
  // *************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Write: address and data together, each released when taken
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; awa <= {ix, 2'b00}; wd <= d; brd <= 1'b1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
      if (bv) break;
    end
    chk(bresp, er);
    brd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ix, output logic [31:0] q);
    @(posedge clk);
    arv <= 1'b1; ara <= {ix, 2'b00}; rrd <= 1'b1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    q = rdat;
    chk(rresp, er);
    rrd <= 1'b0;
  endtask

  // 16-bit registers travel as low byte then high byte
  task automatic setp(input logic [7:0] ix, input logic [15:0] v);
    wr(ix, {24'h00_0000, v[7:0]});
    wr(ix + 8'h01, {24'h00_0000, v[15:8]});
  endtask

  task automatic getp(input logic [7:0] ix, output logic [15:0] v);
    logic [31:0] d;
    rd(ix, d);
    v[7:0] = d[7:0];
    rd(ix + 8'h01, d);
    v[15:8] = d[7:0];
  endtask

  task automatic rst(input logic s);
    rstn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Byte mode returns only the low lane
  function automatic logic [15:0] rx_exp(input logic [15:0] p, input bit b);
    return (p ^ 16'h5a3c) & (b ? 16'h00ff : 16'hffff);
  endfunction

  // *************************************************
  // Main sequence: word mode first, byte mode after a second reset
  // *************************************************
  initial begin
    logic [31:0] d;
    logic [15:0] a, v, s, m6;
    logic [7:0]  lo [3];
    int          st;
    lo = '{sram_access_pkg::idx_rd_addr_low, sram_access_pkg::idx_wr_addr_low,
           sram_access_pkg::idx_len_low};
    er = sram_access_pkg::resp_okay;
    d = $urandom(20);
    for (int m = 0; m < 2; m++) begin
      st = m ? 1 : 2;
      rst(m[0]);
      foreach (lo[i]) begin
        v = 16'($urandom);
        setp(lo[i], v);
        getp(lo[i], a);
        chk(a, v);
      end
      chk(tlen, v);
      // Hold port, then two advancing writes, pointer read back after each
      a = 16'h0100 + 16'($urandom_range(255));
      setp(sram_access_pkg::idx_wr_addr_low, a);
      for (int k = 0; k < 3; k++) begin
        d = $urandom;
        wr(k ? sram_access_pkg::idx_tx_advance
             : sram_access_pkg::idx_tx_hold, d);
        // The capture flop updates at the response edge; look after it
        @(negedge clk);
        chk(last_wr, {1'b1, a, d[15:0], ~m[0]});
        if (k > 0) a = a + 16'(st);
        getp(sram_access_pkg::idx_wr_addr_low, v);
        chk(v, a);
      end
      // Peek keeps the pointer and prefetches, advance moves it
      a = 16'h0200 + 16'($urandom_range(127)) * 16'h0002;
      setp(sram_access_pkg::idx_rd_addr_low, a);
      for (int k = 0; k < 2; k++) begin
        rd(k ? sram_access_pkg::idx_rx_advance
             : sram_access_pkg::idx_rx_peek, d);
        chk(d, {16'h0000, rx_exp(a, m[0])});
        if (k > 0) a = a + 16'(st);
        chk(rxa, a);
      end
      chk(n_pf, m + 1);
      // Last step before the buffer end, with and without wrap
      wr(sram_access_pkg::idx_enable, 32'h0000_0080);
      rd(sram_access_pkg::idx_rd_addr_high, d);
      chk(d[7:0], sram_access_pkg::wrap_high_value);
      for (int k = 0; k < 2; k++) begin
        a = 16'h4000 - 16'(st);
        setp(sram_access_pkg::idx_wr_addr_low, a);
        wr(sram_access_pkg::idx_tx_advance, $urandom);
        getp(sram_access_pkg::idx_wr_addr_low, v);
        chk(v, k ? 16'h4000 : 16'h0c00);
        setp(sram_access_pkg::idx_rd_addr_low, a);
        rd(sram_access_pkg::idx_rx_advance, d);
        chk(rxa, k ? 16'h4000 : 16'h0c00);
        wr(sram_access_pkg::idx_enable, 32'h0000_0000);
      end
      // Events set flags, write-one clears; bits 7 and 6 written are ignored
      m6 = 16'($urandom_range(63)) | 16'h0001;
      wr(sram_access_pkg::idx_enable, {16'h0000, m6});
      s = 16'h0000;
      for (int p = 0; p < 2; p++) begin
        for (int b = 0; b < 6; b++) begin
          if (p > 0) begin
            wr(sram_access_pkg::idx_status,
               32'(1 << b) | 32'h0000_00c0);
          end else begin
            ev <= sram_access_pkg::events_t'(6'(1 << b));
            @(posedge clk);
            ev <= '0;
          end
          s[b] = (p == 0);
          rd(sram_access_pkg::idx_status, d);
          chk(d[7:0], {m[0], 1'b0, s[5:0]});
          chk(irq, |(s[5:0] & m6[5:0]));
        end
      end
      // Unmapped index is refused with no effect
      er = sram_access_pkg::resp_slverr;
      wr(8'h10, $urandom);
      rd(8'h10, d);
      er = sram_access_pkg::resp_okay;
    end
    summarize();
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule // sram_access_irq_regs_tb_top
`default_nettype wire
